// file: baud_gen.sv
// Top of the serial rate generator: prescaler, rate divider and bit clock.
`timescale 1ns/1ps
`default_nettype none
module baud_gen
    import baud_pkg::*;
#(
    parameter int RATE_W = RATE_CNT_W
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [PRESCALE_W-1:0] RATE_PRESCALE_SELECT,
    input wire logic [DIVIDE_W-1:0] RATE_DIVIDE_SELECT,
    input wire logic TEST_MODE,
    input wire logic BAUD_CLOCK_CHECK_WR,
    input wire logic TX_DATA_IN,
    output logic BAUD_CLOCK_CHECK_TEST,
    output logic RX_SAMPLE_TICK,
    output logic TX_BIT_TICK,
    output logic TXD_OUT
);
    // ****************************************
    // Setting tracking
    // ****************************************
    logic [PRESCALE_W-1:0] pre_reg;
    logic [DIVIDE_W-1:0] div_reg;
    logic restart;
    logic pre_tick;
    logic sample_tick;
    logic bit_tick;
    logic sample_clk_reg;
    logic bit_clk_reg;
    logic [PRE_CNT_W-1:0] pre_term;
    logic [RATE_W-1:0] rate_term;
    // Wide enough for the slowest setting, thirteen times 128.
    localparam int SPAN_W = PRE_CNT_W + RATE_W;
    logic [SPAN_W-1:0] since_reg;
    logic since_ok_reg;
    logic [BIT_CNT_W-1:0] pairs_reg;
    logic pairs_ok_reg;

    // Map prescaler code to its divide factor.
    function automatic logic [PRE_CNT_W-1:0] pre_factor(
        input logic [PRESCALE_W-1:0] code
    );
        case (code)
            PRE_CODE_1: pre_factor = PRE_DIV_1;
            PRE_CODE_3: pre_factor = PRE_DIV_3;
            PRE_CODE_4: pre_factor = PRE_DIV_4;
            PRE_CODE_13: pre_factor = PRE_DIV_13;
            default: pre_factor = PRE_DIV_1;
        endcase
    endfunction

    // Remember the last setting so a change restarts the chain.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pre_reg <= '0;
            div_reg <= '0;
        end else begin
            pre_reg <= RATE_PRESCALE_SELECT;
            div_reg <= RATE_DIVIDE_SELECT;
        end
    end

    // A change costs one partial period but avoids a stale terminal count.
    assign restart = (pre_reg != RATE_PRESCALE_SELECT) ||
                     (div_reg != RATE_DIVIDE_SELECT);

    // ****************************************
    // Divider chain
    // ****************************************
    // One setting drives both directions.
    assign pre_term = pre_factor(RATE_PRESCALE_SELECT) - 1'b1;
    assign rate_term = RATE_W'((1 << RATE_DIVIDE_SELECT) - 1);

    // Prescaler stage fed from the processor clock.
    pulse_divider #(.W(PRE_CNT_W)) u_pre (
        .CLK(CLK),
        .NRST(NRST),
        .restart(restart),
        .tick_in(1'b1),
        .terminal(pre_term),
        .tick_out(pre_tick)
    );

    // Rate-select stage gives the sample clock.
    pulse_divider #(.W(RATE_W)) u_rate (
        .CLK(CLK),
        .NRST(NRST),
        .restart(restart),
        .tick_in(pre_tick),
        .terminal(rate_term),
        .tick_out(sample_tick)
    );

    // Fixed divide-by-sixteen for the bit clock.
    pulse_divider #(.W(BIT_CNT_W)) u_bit (
        .CLK(CLK),
        .NRST(NRST),
        .restart(restart),
        .tick_in(sample_tick),
        .terminal(BIT_CNT_W'(BIT_DIV - 1)),
        .tick_out(bit_tick)
    );

    // Registered ticks so outputs come from flip-flops.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RX_SAMPLE_TICK <= 1'b0;
            TX_BIT_TICK <= 1'b0;
        end else begin
            RX_SAMPLE_TICK <= sample_tick;
            TX_BIT_TICK <= bit_tick;
        end
    end

    // Square-wave views of both clocks for the check output.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sample_clk_reg <= 1'b0;
            bit_clk_reg <= 1'b0;
        end else if (restart) begin
            sample_clk_reg <= 1'b0;
            bit_clk_reg <= 1'b0;
        end else begin
            if (sample_tick) begin
                sample_clk_reg <= !sample_clk_reg;
            end
            if (bit_tick) begin
                bit_clk_reg <= !bit_clk_reg;
            end
        end
    end

    // ****************************************
    // Factory test bit and pin mux
    // ****************************************
    // Test bit is held clear whenever the part is not in test mode.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            BAUD_CLOCK_CHECK_TEST <= 1'b0;
        end else if (!TEST_MODE) begin
            BAUD_CLOCK_CHECK_TEST <= 1'b0;
        end else begin
            BAUD_CLOCK_CHECK_TEST <= BAUD_CLOCK_CHECK_WR;
        end
    end

    // Transmit pin carries data, or the clock XOR while checking.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TXD_OUT <= 1'b1;
        end else if (BAUD_CLOCK_CHECK_TEST) begin
            TXD_OUT <= sample_clk_reg ^ bit_clk_reg;
        end else begin
            TXD_OUT <= TX_DATA_IN;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Cycles since the last sample tick. A restart voids the count, so the
    // first tick after a change is never judged against a stale period.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            since_reg <= '0;
            since_ok_reg <= 1'b0;
        end else if (restart) begin
            since_reg <= '0;
            since_ok_reg <= 1'b0;
        end else if (RX_SAMPLE_TICK) begin
            since_reg <= SPAN_W'(1);
            since_ok_reg <= 1'b1;
        end else begin
            since_reg <= since_reg + 1'b1;
        end
    end

    // Sample ticks strictly between two bit ticks, for the pairing check.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pairs_reg <= '0;
            pairs_ok_reg <= 1'b0;
        end else if (restart) begin
            pairs_reg <= '0;
            pairs_ok_reg <= 1'b0;
        end else if (TX_BIT_TICK) begin
            pairs_reg <= '0;
            pairs_ok_reg <= 1'b1;
        end else if (RX_SAMPLE_TICK) begin
            pairs_reg <= pairs_reg + 1'b1;
        end
    end

    sequence s_outside_test;
        !TEST_MODE;
    endsequence

    sequence s_settled_sample;
        RX_SAMPLE_TICK && since_ok_reg && !restart;
    endsequence

    sequence s_settled_bit;
        TX_BIT_TICK && pairs_ok_reg && !restart;
    endsequence

    AST_TEST_ZERO: assert property (
        @(posedge CLK) disable iff (!NRST)
        s_outside_test |=> !BAUD_CLOCK_CHECK_TEST)
        else $error("Test bit set outside test mode.");
    AST_TEST_SET: assert property (
        @(posedge CLK) disable iff (!NRST)
        TEST_MODE && BAUD_CLOCK_CHECK_WR |=> BAUD_CLOCK_CHECK_TEST)
        else $error("Test bit not set in test mode.");
    AST_XOR_OUT: assert property (
        @(posedge CLK) disable iff (!NRST)
        BAUD_CLOCK_CHECK_TEST |=>
        TXD_OUT == ($past(sample_clk_reg) ^ $past(bit_clk_reg)))
        else $error("Check output is not the clock XOR.");
    AST_DATA_OUT: assert property (
        @(posedge CLK) disable iff (!NRST)
        !BAUD_CLOCK_CHECK_TEST |=> TXD_OUT == $past(TX_DATA_IN))
        else $error("Transmit pin does not follow data.");
    AST_BIT_ON_SAMPLE: assert property (
        @(posedge CLK) disable iff (!NRST)
        TX_BIT_TICK |-> RX_SAMPLE_TICK)
        else $error("Bit tick without sample tick.");
    AST_BIT_PAIRS: assert property (
        @(posedge CLK) disable iff (!NRST)
        s_settled_bit |-> pairs_reg == BIT_CNT_W'(BIT_DIV - 1))
        else $error("Bit tick not after sixteen sample ticks.");
    AST_SAMPLE_PERIOD: assert property (
        @(posedge CLK) disable iff (!NRST)
        s_settled_sample |->
        since_reg == (SPAN_W'(pre_factor(RATE_PRESCALE_SELECT))
            << RATE_DIVIDE_SELECT))
        else $error("Sample period does not match the setting.");
    AST_FAST_SPACING: assert property (
        @(posedge CLK) disable iff (!NRST)
        (RATE_PRESCALE_SELECT == PRE_CODE_3 && RATE_DIVIDE_SELECT == 3'h0
         && !restart && RX_SAMPLE_TICK) |=> !RX_SAMPLE_TICK [*2])
        else $error("Sample ticks too close for divide by three.");
    AST_NO_TICK_RESTART: assert property (
        @(posedge CLK) disable iff (!NRST)
        restart |=> !RX_SAMPLE_TICK)
        else $error("Sample tick right after a setting change.");
    AST_SAMPLE_RATE1: assert property (
        @(posedge CLK) disable iff (!NRST)
        (RATE_PRESCALE_SELECT == PRE_CODE_1 && RATE_DIVIDE_SELECT == 3'h1
         && !restart && $past(!restart)) |-> ##1 $changed(RX_SAMPLE_TICK))
        else $error("Divide by two does not alternate.");
endmodule
`default_nettype wire

// file: baud_pkg.sv
// Package with constants for the serial rate generator.
package baud_pkg;
    // ****************************************
    // Field widths and prescaler codes
    // ****************************************
    localparam int PRESCALE_W = 2;
    localparam int DIVIDE_W = 3;
    localparam int PRE_CNT_W = 4;
    localparam logic [PRESCALE_W-1:0] PRE_CODE_1 = 2'h0;
    localparam logic [PRESCALE_W-1:0] PRE_CODE_3 = 2'h1;
    localparam logic [PRESCALE_W-1:0] PRE_CODE_4 = 2'h2;
    localparam logic [PRESCALE_W-1:0] PRE_CODE_13 = 2'h3;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_1 = 4'h1;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_3 = 4'h3;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_4 = 4'h4;
    localparam logic [PRE_CNT_W-1:0] PRE_DIV_13 = 4'hD;
    // ****************************************
    // Divider chain
    // ****************************************
    localparam int RATE_CNT_W = 7;
    localparam int BIT_DIV = 16;
    localparam int BIT_CNT_W = 4;
endpackage

// file: pulse_divider.sv
// Generic enable-pulse divider used by the rate chain.
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
    parameter int W = 4
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic restart,
    input wire logic tick_in,
    input wire logic [W-1:0] terminal,
    output logic tick_out
);
    logic [W-1:0] count_reg;

    // Counts input ticks; emits one pulse when the terminal count is hit.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            count_reg <= '0;
        end else if (restart) begin
            count_reg <= '0;
        end else if (tick_in) begin
            if (count_reg == terminal) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // Combinational pulse keeps chained stages aligned to one clock.
    assign tick_out = tick_in && !restart && (count_reg == terminal);
endmodule
`default_nettype wire

// file: shift_model.sv
// Model of the serial shift logic that the rate generator feeds.
`timescale 1ns/1ps
`default_nettype none
module shift_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_tick,
    input wire logic bit_tick,
    output logic tx_data,
    output logic [7:0] samples_per_bit
);
    // ****************************************
    // Shifter and sample counter
    // ****************************************
    logic [7:0] pattern_reg;
    logic [7:0] count_reg;
    // One data bit per bit tick; the samples of each bit are counted too.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pattern_reg <= 8'hB4;
            count_reg <= 8'h00;
            samples_per_bit <= 8'h00;
        end else if (bit_tick) begin
            pattern_reg <= {pattern_reg[6:0], pattern_reg[7]};
            samples_per_bit <= count_reg + {7'h00, rx_tick};
            count_reg <= 8'h00;
        end else begin
            count_reg <= count_reg + {7'h00, rx_tick};
        end
    end
    assign tx_data = pattern_reg[7];
endmodule
`default_nettype wire

// file: baud_gen_tb.sv
// Self-checking testbench of the serial rate generator.
`timescale 1ns/1ps
`default_nettype none
module baud_gen_tb;
    // ****************************************
    // Bench
    // ****************************************
    int fails = 0;
    int checks = 0;
    int pre_tab [4] = '{1, 3, 4, 13};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic test_mode = 1'b0;
    logic check_wr = 1'b0;
    logic [1:0] pre_sel = 2'h0;
    logic [2:0] div_sel = 3'h0;
    logic tx_data, check_bit, rx_tick, bit_tick, txd;
    logic [7:0] spb;
    // Clock of 100 MHz.
    always #5 clk = ~clk;
    baud_gen i_baud_gen (.CLK(clk), .NRST(nrst),
        .RATE_PRESCALE_SELECT(pre_sel), .RATE_DIVIDE_SELECT(div_sel),
        .TEST_MODE(test_mode), .BAUD_CLOCK_CHECK_WR(check_wr),
        .TX_DATA_IN(tx_data), .BAUD_CLOCK_CHECK_TEST(check_bit),
        .RX_SAMPLE_TICK(rx_tick), .TX_BIT_TICK(bit_tick), .TXD_OUT(txd));
    shift_model i_shift_model (.clk(clk), .nrst(nrst), .rx_tick(rx_tick),
        .bit_tick(bit_tick), .tx_data(tx_data), .samples_per_bit(spb));
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen,
            input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %0d seen %0d", name, exp, seen);
        end
    endtask
    // Counts edges up to the next tick; a lost tick ends the run.
    task automatic gap(input bit use_bit, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((use_bit ? bit_tick : rx_tick) !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            fails++;
            summarize();
        end
    endtask
    task automatic t_reset();
        int n;
        test_mode = 1'b1;
        check_wr = 1'b1;
        pre_sel = 2'h1;
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b0;
        @(posedge clk);
        #1;
        check("reset", {rx_tick, check_bit, txd}, 16'h1);
        nrst = 1'b1;
        gap(0, n);
        check("first tick", 16'(n >= 2 && n <= 4), 16'h1);
        test_mode = 1'b0;
        $display("reset test done");
    endtask
    task automatic t_rates();
        int n;
        for (int p = 0; p < 4; p++) begin
            for (int d = 0; d < 8; d++) begin
                pre_sel = p[1:0];
                div_sel = d[2:0];
                gap(0, n);
                gap(0, n);
                check("period", 16'(n), 16'(pre_tab[p] << d));
            end
        end
        $display("rate test done");
    endtask
    task automatic t_bit();
        pre_sel = 2'h1;
        div_sel = 3'h1;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (bit_tick === 1'b1) check("coincide", rx_tick, 16'h1);
        end
        check("samples per bit", spb, 16'h10);
        $display("bit test done");
    endtask
    task automatic t_test();
        int n;
        int c = 0;
        logic prev;
        repeat (2) @(posedge clk);
        #1;
        check("test bit off", check_bit, 16'h0);
        test_mode = 1'b1;
        pre_sel = 2'h2;
        div_sel = 3'h0;
        repeat (2) @(posedge clk);
        #1;
        check("test bit on", check_bit, 16'h1);
        gap(1, n);
        @(posedge clk);
        #1;
        prev = txd;
        repeat (64) begin
            @(posedge clk);
            #1;
            c += int'(txd !== prev);
            prev = txd;
        end
        check("xor edges", 16'(c), 16'hF);
        check_wr = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("test bit cleared", check_bit, 16'h0);
        test_mode = 1'b0;
        pre_sel = 2'h0;
        repeat (40) begin
            prev = tx_data;
            @(posedge clk);
            #1;
            check("data out", txd, prev);
        end
        $display("test bit test done");
    endtask
    task automatic t_restart();
        int n;
        pre_sel = 2'h3;
        div_sel = 3'h3;
        gap(0, n);
        gap(0, n);
        repeat (50) @(posedge clk);
        #1;
        div_sel = 3'h2;
        gap(0, n);
        check("restart", 16'(n >= 51 && n <= 55), 16'h1);
        $display("restart test done");
    endtask
    // Reset for three cycles, then the scenarios in turn.
    initial begin
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_rates();
        t_bit();
        t_test();
        t_restart();
        summarize();
    end
endmodule
`default_nettype wire
